// ---- src/dem_exec_monitor.sv ----
// Purpose: execution monitor beside the audio core: capture, timeout, block count, pointer
// Assumes: every input is synchronous to core_clk
// Notes:   register port answers reads one cycle later, never stalls
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module dem_exec_monitor
  import dem_pkg::*;
#(
  parameter int STEP_BASE_CYCLES = `DEM_STEP_BASE
) (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // register port
  input  wire dem_bus_req_t           bus_req,
  output logic [`DEM_DATA_W-1:0]      bus_rdata,
  // core events
  input  wire dem_core_evt_t          core_evt,
  // instruction pointer toward the core
  output logic [`DEM_IP_W-1:0]        ip_value,
  // panic manager and peak tracker
  output logic                        timeout_err,
  output logic [`DEM_DATA_W-1:0]      timeout_panic_code,
  output logic                        peak_length_clear,
  // block event toward the core
  output logic                        block_irq,
  // interrupt line
  output logic                        irq
);
  if (STEP_BASE_CYCLES < 2) begin : g_chk
    $error("STEP_BASE_CYCLES must be at least 2");
  end

  dem_top_state_t st_q;
  dem_top_state_t st_d;
  logic           step_tick;
  logic           grp_irq;
  logic           wd_evt;
  logic           restart;
  logic [`DEM_ST_W-1:0] events;

  function automatic logic wr_hit(input dem_bus_req_t r, input logic [`DEM_DATA_W-1:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pacing and block counting

  assign restart = core_evt.wd_reload;

  dem_step_timer #(
    .BASE_CYCLES (STEP_BASE_CYCLES)
  ) u_step (
    .core_clk (core_clk),
    .rst      (rst),
    .code     (st_q.wd_step[`DEM_STEP_MSB:0]),
    .restart  (restart),
    .tick     (step_tick)
  );

  dem_frame_group u_group (
    .core_clk    (core_clk),
    .rst         (rst),
    .frame_start (core_evt.frame_start),
    .length      (st_q.grp_len),
    .enable      (st_q.grp_en[`DEM_GRP_EN_BIT]),
    .group_irq   (grp_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;
    wd_evt = 1'b0;

    // software writes to plain registers
    if (wr_hit(bus_req, `DEM_OFS_CAP_LO)) begin
      st_d.cap_lo = bus_req.wdata;
    end
    if (wr_hit(bus_req, `DEM_OFS_CAP_HI)) begin
      st_d.cap_hi = bus_req.wdata;
    end
    if (wr_hit(bus_req, `DEM_OFS_WD_START)) begin
      st_d.wd_start = bus_req.wdata;
    end
    if (wr_hit(bus_req, `DEM_OFS_WD_STEP)) begin
      st_d.wd_step = bus_req.wdata;
    end
    if (wr_hit(bus_req, `DEM_OFS_GRP_EN)) begin
      st_d.grp_en = bus_req.wdata;
    end
    if (wr_hit(bus_req, `DEM_OFS_GRP_LEN)) begin
      st_d.grp_len = bus_req.wdata;
    end
    if (wr_hit(bus_req, `DEM_OFS_IP_FREEZE)) begin
      st_d.freeze = bus_req.wdata;
    end
    if (wr_hit(bus_req, `DEM_OFS_IRQ_ENABLE)) begin
      st_d.irq_en = bus_req.wdata[`DEM_ST_W-1:0];
    end

    // capture wins over a write in the same cycle
    if (core_evt.sw_error) begin
      st_d.cap_lo = core_evt.instr[`DEM_DATA_W-1:0];
      st_d.cap_hi = core_evt.instr[`DEM_INSTR_W-1:`DEM_DATA_W];
    end

    // timeout down-count; idle until the core first signals wd_reload,
    // so a zero start value after reset does not fire on its own
    if (restart) begin
      st_d.wd_cnt = st_q.wd_start[`DEM_WD_MSB:0];
      st_d.wd_state = DEM_WD_RUN;
    end else begin
      unique case (st_q.wd_state)
        DEM_WD_IDLE: begin
          st_d.wd_state = DEM_WD_IDLE;
        end
        DEM_WD_RUN: begin
          if (st_q.wd_cnt == `DEM_WD_RESET) begin
            st_d.wd_state = DEM_WD_EXPIRED;
            wd_evt = 1'b1;
          end else if (step_tick) begin
            st_d.wd_cnt = st_q.wd_cnt - 1'b1;
          end
        end
        DEM_WD_EXPIRED: begin
          st_d.wd_state = DEM_WD_EXPIRED;
        end
        default: begin
          st_d.wd_state = DEM_WD_IDLE;
        end
      endcase
    end
    st_d.wd_err = wd_evt;
    st_d.panic_code = wd_evt ? (`DEM_REG_RESET | (16'h0001 << `DEM_PANIC_WD_BIT)) : `DEM_REG_RESET;

    // instruction pointer
    if (st_q.freeze[`DEM_FREEZE_BIT]) begin
      st_d.ip = `DEM_IP_RESET;
    end else if (core_evt.ip_update) begin
      st_d.ip = core_evt.ip_next;
    end
    // falling edge of the written freeze bit
    st_d.peak_clr = st_q.freeze[`DEM_FREEZE_BIT] & ~st_d.freeze[`DEM_FREEZE_BIT];

    // sticky status, a new event beats a clear in the same cycle
    events = '0;
    events[`DEM_ST_TIMEOUT] = wd_evt;
    events[`DEM_ST_GROUP] = grp_irq;
    events[`DEM_ST_SWERR] = core_evt.sw_error;
    st_d.status = st_q.status;
    if (wr_hit(bus_req, `DEM_OFS_IRQ_CLEAR)) begin
      st_d.status = st_q.status & ~bus_req.wdata[`DEM_ST_W-1:0];
    end
    st_d.status = st_d.status | events;
    st_d.irq = |(st_d.status & st_d.irq_en);

    // read data only in the cycle after the strobe
    st_d.rdata = `DEM_REG_RESET;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `DEM_OFS_CAP_LO:     st_d.rdata = st_q.cap_lo;
        `DEM_OFS_CAP_HI:     st_d.rdata = st_q.cap_hi;
        `DEM_OFS_WD_START:   st_d.rdata = st_q.wd_start;
        `DEM_OFS_WD_STEP:    st_d.rdata = st_q.wd_step;
        `DEM_OFS_GRP_EN:     st_d.rdata = st_q.grp_en;
        `DEM_OFS_GRP_LEN:    st_d.rdata = st_q.grp_len;
        `DEM_OFS_IP_HIGH:    st_d.rdata = {8'h00, st_q.ip[`DEM_IP_W-1:`DEM_DATA_W]};
        `DEM_OFS_IP_LOW:     st_d.rdata = st_q.ip[`DEM_DATA_W-1:0];
        `DEM_OFS_IP_FREEZE:  st_d.rdata = st_q.freeze;
        `DEM_OFS_IRQ_STATUS: st_d.rdata = {13'h0000, st_q.status};
        `DEM_OFS_IRQ_ENABLE: st_d.rdata = {13'h0000, st_q.irq_en};
        default:             st_d.rdata = `DEM_REG_RESET;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= '{
        cap_lo:     `DEM_REG_RESET,
        cap_hi:     `DEM_REG_RESET,
        wd_start:   `DEM_REG_RESET,
        wd_step:    `DEM_REG_RESET,
        grp_en:     `DEM_REG_RESET,
        grp_len:    `DEM_REG_RESET,
        freeze:     `DEM_REG_RESET,
        ip:         `DEM_IP_RESET,
        wd_cnt:     `DEM_WD_RESET,
        wd_state:   DEM_WD_IDLE,
        wd_err:     1'b0,
        panic_code: `DEM_REG_RESET,
        status:     `DEM_ST_RESET,
        irq_en:     `DEM_ST_RESET,
        irq:        1'b0,
        peak_clr:   1'b0,
        rdata:      `DEM_REG_RESET
      };
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign bus_rdata          = st_q.rdata;
  assign ip_value           = st_q.ip;
  assign timeout_err        = st_q.wd_err;
  assign timeout_panic_code = st_q.panic_code;
  assign peak_length_clear  = st_q.peak_clr;
  assign block_irq          = grp_irq;
  assign irq                = st_q.irq;
endmodule
`default_nettype wire

// ---- src/dem_frame_group.sv ----
// Purpose: counts audio frame starts and flags the end of each block
// Assumes: frame_start is a one-cycle pulse on core_clk
// Notes:   counter keeps running while disabled, only the flag is gated
`timescale 1ns/1ps
`default_nettype none
module dem_frame_group
  import dem_pkg::*;
(
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // frame input and settings
  input  wire logic                   frame_start,
  input  wire logic [`DEM_DATA_W-1:0] length,
  input  wire logic                   enable,
  // block event
  output logic                        group_irq
);
  typedef struct packed {
    logic [`DEM_DATA_W-1:0] cnt;
    logic                   irq;
  } dem_grp_state_t;

  dem_grp_state_t st_q;
  dem_grp_state_t st_d;
  logic [`DEM_DATA_W-1:0] nxt;

  always_comb begin
    st_d = st_q;
    st_d.irq = 1'b0;
    nxt = st_q.cnt + 1'b1;
    if (frame_start) begin
      if (nxt == length) begin
        st_d.cnt = '0;
        st_d.irq = enable;
      end else begin
        st_d.cnt = nxt;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign group_irq = st_q.irq;
endmodule
`default_nettype wire

// ---- src/dem_map.svh ----
// Purpose: register offsets, field positions and reset values of the execution monitor
// Assumes: included by its bare name from the package
// Notes:   offsets are the word addresses seen on the register port
`ifndef DEM_MAP_SVH
`define DEM_MAP_SVH

// register offsets
`define DEM_OFS_CAP_LO     16'hf433
`define DEM_OFS_CAP_HI     16'hf434
`define DEM_OFS_WD_START   16'hf443
`define DEM_OFS_WD_STEP    16'hf444
`define DEM_OFS_GRP_EN     16'hf450
`define DEM_OFS_GRP_LEN    16'hf451
`define DEM_OFS_IP_HIGH    16'hf460
`define DEM_OFS_IP_LOW     16'hf461
`define DEM_OFS_IP_FREEZE  16'hf462
`define DEM_OFS_IRQ_STATUS 16'hf470
`define DEM_OFS_IRQ_CLEAR  16'hf471
`define DEM_OFS_IRQ_ENABLE 16'hf472

// widths and field positions
`define DEM_DATA_W         16
`define DEM_INSTR_W        32
`define DEM_IP_W           24
`define DEM_WD_W           13
`define DEM_WD_MSB         12
`define DEM_STEP_MSB       3
`define DEM_STEP_CODE_W    4
`define DEM_STEP_MAX_CODE  4'hb
`define DEM_STEP_BASE      64
`define DEM_GRP_EN_BIT     0
`define DEM_FREEZE_BIT     0
`define DEM_IP_HIGH_MSB    7
`define DEM_PANIC_WD_BIT   12

// interrupt status layout
`define DEM_ST_W           3
`define DEM_ST_TIMEOUT     0
`define DEM_ST_GROUP       1
`define DEM_ST_SWERR       2

// reset values
`define DEM_REG_RESET      16'h0000
`define DEM_IP_RESET       24'h00_0000
`define DEM_WD_RESET       13'h0000
`define DEM_ST_RESET       3'h0

`endif

// ---- src/dem_pkg.sv ----
// Purpose: shared types of the execution monitor
// Assumes: dem_map.svh holds every number except the timeout state encodings defined here
// Notes:   bus request and core events travel as packed structs
package dem_pkg;
  `include "dem_map.svh"

  typedef enum logic [2:0] {
    DEM_WD_IDLE    = 3'h1,
    DEM_WD_RUN     = 3'h2,
    DEM_WD_EXPIRED = 3'h4
  } dem_wd_state_t;

  typedef struct packed {
    logic [`DEM_DATA_W-1:0] addr;
    logic [`DEM_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } dem_bus_req_t;

  typedef struct packed {
    logic                    sw_error;
    logic [`DEM_INSTR_W-1:0] instr;
    logic                    frame_start;
    logic                    wd_reload;
    logic                    ip_update;
    logic [`DEM_IP_W-1:0]    ip_next;
  } dem_core_evt_t;

  typedef struct packed {
    logic [`DEM_DATA_W-1:0] cap_lo;
    logic [`DEM_DATA_W-1:0] cap_hi;
    logic [`DEM_DATA_W-1:0] wd_start;
    logic [`DEM_DATA_W-1:0] wd_step;
    logic [`DEM_DATA_W-1:0] grp_en;
    logic [`DEM_DATA_W-1:0] grp_len;
    logic [`DEM_DATA_W-1:0] freeze;
    logic [`DEM_IP_W-1:0]   ip;
    logic [`DEM_WD_W-1:0]   wd_cnt;
    dem_wd_state_t          wd_state;
    logic                   wd_err;
    logic [`DEM_DATA_W-1:0] panic_code;
    logic [`DEM_ST_W-1:0]   status;
    logic [`DEM_ST_W-1:0]   irq_en;
    logic                   irq;
    logic                   peak_clr;
    logic [`DEM_DATA_W-1:0] rdata;
  } dem_top_state_t;
endpackage

// ---- src/dem_step_timer.sv ----
// Purpose: prescaler that paces the timeout down-count
// Assumes: code and restart come from logic on core_clk
// Notes:   period is base << code, codes above the top one clamp to it
`timescale 1ns/1ps
`default_nettype none
module dem_step_timer
  import dem_pkg::*;
#(
  parameter int BASE_CYCLES = `DEM_STEP_BASE
) (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // control
  input  wire logic [`DEM_STEP_CODE_W-1:0] code,
  input  wire logic                        restart,
  // step pulse
  output logic                             tick
);
  localparam int CNT_W = $clog2(BASE_CYCLES) + 12;

  if (BASE_CYCLES < 2 || (BASE_CYCLES & (BASE_CYCLES - 1)) != 0) begin : g_chk
    $error("BASE_CYCLES must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } dem_step_state_t;

  dem_step_state_t st_q;
  dem_step_state_t st_d;
  logic [`DEM_STEP_CODE_W-1:0] code_eff;
  logic [CNT_W-1:0]            last;

  always_comb begin
    // undefined codes behave as the slowest one
    code_eff = (code > `DEM_STEP_MAX_CODE) ? `DEM_STEP_MAX_CODE : code;
    last = CNT_W'((BASE_CYCLES << code_eff) - 1);
    st_d = st_q;
    st_d.tick = 1'b0;
    if (restart) begin
      st_d.cnt = '0;
    end else if (st_q.cnt >= last) begin
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;
endmodule
`default_nettype wire

// ---- testbench/dem_chk_monitor.sv ----
// Purpose: port-level checks of the execution monitor
// Assumes: settings change only through writes seen on bus_req
// Notes:   timeout window accepts from lim up to two cycles past lim
`timescale 1ns/1ps
`default_nettype none
module dem_chk
  import dem_pkg::*;
#(
  parameter int STEP_BASE_CYCLES = 64
) (
  // clock and reset
  input wire logic          core_clk,
  input wire logic          rst,
  // watched ports
  input wire dem_bus_req_t  bus_req,
  input wire logic [15:0]   bus_rdata,
  input wire dem_core_evt_t core_evt,
  input wire logic [23:0]   ip_value,
  input wire logic          timeout_err,
  input wire logic [15:0]   timeout_panic_code,
  input wire logic          peak_length_clear,
  input wire logic          block_irq,
  input wire logic          irq
);
  ////////////////////////////////////////
  logic [15:0] st_q;
  logic [15:0] cd_q;
  logic        frz_q;
  logic        en_q;
  logic        fclr;
  logic        fs_en;
  int          cyc_q;
  int          lim;
  assign fclr = bus_req.wr && bus_req.addr == 16'hf462 && !bus_req.wdata[0] && frz_q;
  assign fs_en = core_evt.frame_start && en_q;
  // codes above the top one clamp, as the step timer does
  assign lim = st_q[12:0] * (STEP_BASE_CYCLES << (cd_q[3:0] > 4'hb ? 4'hb : cd_q[3:0]));
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      cd_q <= '0;
      frz_q <= 1'b0;
      en_q <= 1'b0;
      cyc_q <= 0;
    end else begin
      if (bus_req.wr && bus_req.addr == 16'hf443) st_q <= bus_req.wdata;
      if (bus_req.wr && bus_req.addr == 16'hf444) cd_q <= bus_req.wdata;
      if (bus_req.wr && bus_req.addr == 16'hf462) frz_q <= bus_req.wdata[0];
      if (bus_req.wr && bus_req.addr == 16'hf450) en_q <= bus_req.wdata[0];
      cyc_q <= core_evt.wd_reload ? 0 : cyc_q + 1;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_panic_pair: assert property (timeout_panic_code == (timeout_err ? 16'h1000 : 16'h0000))
    else $error("panic code disagrees with timeout pulse");
  a_err_single: assert property (timeout_err |=> !timeout_err)
    else $error("timeout pulse longer than one cycle");
  a_timeout_window: assert property (timeout_err |-> cyc_q >= lim && cyc_q <= lim + 2)
    else $error("timeout at wrong distance from reload");
  a_freeze_hold: assert property (frz_q |=> ip_value == 24'h00_0000)
    else $error("pointer moved while frozen");
  a_peak_clear: assert property (fclr |=> peak_length_clear)
    else $error("peak clear missing after freeze release");
  a_ptr_low: assert property (bus_req.rd && bus_req.addr == 16'hf461 |=> bus_rdata == $past(ip_value[15:0]))
    else $error("pointer low word wrong");
  a_ptr_high: assert property (bus_req.rd && bus_req.addr == 16'hf460 |=> bus_rdata == {8'h00, $past(ip_value[23:16])})
    else $error("pointer high word wrong");
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_block_gate: assert property (block_irq |-> $past(fs_en))
    else $error("block event without enabled frame start");
  a_irq_cause: assert property ($rose(irq) |-> $past(bus_req.wr) || $past(core_evt.sw_error) || $past(block_irq) || timeout_err)
    else $error("interrupt rose without cause");
endmodule

bind dem_exec_monitor dem_chk #(.STEP_BASE_CYCLES(STEP_BASE_CYCLES)) dem_chk_i (
  .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .core_evt(core_evt),
  .ip_value(ip_value), .timeout_err(timeout_err), .timeout_panic_code(timeout_panic_code),
  .peak_length_clear(peak_length_clear), .block_irq(block_irq), .irq(irq)
);
`default_nettype wire

// ---- testbench/dem_exec_monitor_tb.sv ----
// Purpose: directed register and event tests of the execution monitor
// Assumes: short step period through STEP_BASE_CYCLES
// Notes:   every wait is bounded; a hang ends the run as a mismatch
`timescale 1ns/1ps
`default_nettype none
module dem_exec_monitor_tb
  import dem_pkg::*;
;
  localparam int STEP = 2;
  localparam logic [15:0] RWA [6] = '{16'hf433, 16'hf434, 16'hf443, 16'hf444, 16'hf450, 16'hf451};
  localparam logic [15:0] ROA [4] = '{16'hf460, 16'hf461, 16'hf470, 16'hf435};
  localparam dem_core_evt_t FRM = '{frame_start: 1'b1, default: '0};
  localparam dem_core_evt_t RLD = '{wd_reload: 1'b1, default: '0};
  logic          core_clk;
  logic          rst;
  dem_bus_req_t  bus_req;
  dem_core_evt_t core_evt;
  logic [15:0]   bus_rdata;
  logic [15:0]   timeout_panic_code;
  logic [23:0]   ip_value;
  logic          timeout_err;
  logic          peak_length_clear;
  logic          block_irq;
  logic          irq;
  int            errors;
  int            tests_run;
  int            nblk;
  int            i;

  dem_exec_monitor #(.STEP_BASE_CYCLES(STEP)) dem_exec_monitor_i (
    .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .core_evt(core_evt),
    .ip_value(ip_value), .timeout_err(timeout_err), .timeout_panic_code(timeout_panic_code),
    .peak_length_clear(peak_length_clear), .block_irq(block_irq), .irq(irq)
  );
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (block_irq === 1'b1) nblk <= nblk + 1;
  end
  task automatic stop_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1;
    chk({16'h0000, bus_rdata}, exp);
  endtask
  task automatic ev(input dem_core_evt_t e);
    @(posedge core_clk);
    core_evt <= e;
    @(posedge core_clk);
    core_evt <= '0;
  endtask
  // reload twice so the second one has to restart a running count
  task automatic wd(input logic [3:0] code);
    int e;
    e = 3 * (STEP << (code > 4'hb ? 4'hb : code)) + 2;
    wr(16'hf444, {12'h000, code});
    ev(RLD);
    tick;
    ev(RLD);
    for (i = 1; i < 20000; i++) begin
      tick;
      if (timeout_err === 1'b1) break;
    end
    chk(32'(i >= e - 1 && i <= e + 1), 1);
    chk({16'h0000, timeout_panic_code}, 16'h1000);
    if (i >= 20000) stop_test;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    stop_test;
  end
  initial begin
    rst = 1'b1;
    bus_req = '0;
    core_evt = '0;
    errors = 0;
    tests_run = 0;
    nblk = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    foreach (RWA[k]) rd(RWA[k], 0);
    foreach (RWA[k]) begin
      wr(RWA[k], 16'ha5c3);
      rd(RWA[k], 16'ha5c3);
      wr(RWA[k], 16'h0000);
    end
    foreach (ROA[k]) wr(ROA[k], 16'hffff);
    foreach (ROA[k]) rd(ROA[k], 0);
    wr(16'hf472, 16'h0004);
    ev('{sw_error: 1'b1, instr: 32'h1234_5678, default: '0});
    #1 chk(irq, 1);
    rd(16'hf433, 16'h5678);
    rd(16'hf434, 16'h1234);
    wr(16'hf472, 16'h0000);
    tick;
    chk(irq, 0);
    rd(16'hf470, 16'h0004);
    wr(16'hf472, 16'h0004);
    tick;
    chk(irq, 1);
    wr(16'hf471, 16'h0004);
    tick;
    chk(irq, 0);
    ev('{ip_update: 1'b1, ip_next: 24'hab_cdef, default: '0});
    rd(16'hf460, 16'h00ab);
    rd(16'hf461, 16'hcdef);
    wr(16'hf462, 16'h0001);
    ev('{ip_update: 1'b1, ip_next: 24'h12_3456, default: '0});
    rd(16'hf461, 16'h0000);
    wr(16'hf462, 16'h0000);
    // the clear pulse stands only in the cycle after the write
    #1;
    chk(peak_length_clear, 1);
    tick;
    chk(peak_length_clear, 0);
    ev('{ip_update: 1'b1, ip_next: 24'h12_3456, default: '0});
    rd(16'hf461, 16'h3456);
    wr(16'hf451, 16'h0003);
    wr(16'hf450, 16'h0001);
    repeat (7) ev(FRM);
    repeat (2) tick;
    chk(nblk, 2);
    wr(16'hf450, 16'h0000);
    repeat (3) ev(FRM);
    repeat (2) tick;
    chk(nblk, 2);
    wr(16'hf450, 16'h0001);
    repeat (2) ev(FRM);
    repeat (2) tick;
    chk(nblk, 3);
    rd(16'hf470, 16'h0002);
    wr(16'hf471, 16'h0007);
    wr(16'hf443, 16'he003);
    rd(16'hf443, 16'he003);
    for (int c = 0; c < 16; c++) wd(4'(c));
    rd(16'hf470, 16'h0001);
    stop_test;
  end
endmodule
`default_nettype wire
